// ---- rcld_defs.svh ----
// Overview of operation
// - cause register clears on read, pin, power-clear
// - watchdog reset sets bit 4, low-voltage holds
// - low-voltage reset sets bit 0, watchdog holds
// - other cause bits read zero, read-only
// - internal reset while power-clear comparator low
// - power-clear reset clears cause register
// - enable bit 7 starts comparator
// - mode bit 1: interrupt or reset
// - flag bit 0 shows low supply when enabled
// - flag bit 0 read-only, writes ignored
// - interrupt follows flag in interrupt mode
// - non-low-voltage resets clear control register
// - low-voltage reset keeps control register
// - control register takes bit and byte writes
// - level select holds four-bit code, ten legal
// - level select kept by low-voltage reset only
`ifndef RCLD_DEFS_SVH
`define RCLD_DEFS_SVH
`define RCLD_ADDR_LVCTRL  16'hff50
`define RCLD_ADDR_LVLSEL  16'hff51
`define RCLD_ADDR_CAUSE   16'hff54
`define RCLD_BIT_ENABLE   7
`define RCLD_BIT_MODE     1
`define RCLD_BIT_FLAG     0
`define RCLD_BIT_WDFLAG   4
`define RCLD_BIT_LVFLAG   0
`define RCLD_RESET_VAL    8'h00
`define RCLD_LEVEL_MAX    4'h9
`define RCLD_SETTLE_US    200
`define RCLD_CLK_MHZ      10
`define RCLD_SETTLE_CYC   (`RCLD_SETTLE_US * `RCLD_CLK_MHZ)
`endif

// ---- rcld_pkg.sv ----
package rcld_pkg;
  typedef logic [7:0]  rcld_byte_t;
  typedef logic [15:0] rcld_addr_t;
  typedef logic [3:0]  rcld_level_t;
  typedef enum logic [2:0] {
    RCLD_SRC_PIN  = 3'b001,
    RCLD_SRC_WDOG = 3'b010,
    RCLD_SRC_LOWV = 3'b100
  } rcld_src_t;
endpackage

// ---- rcld_sync3.sv ----
`timescale 1ns/1ps
module rcld_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  // a bit moves only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          s1_q[i]    <= 1'b1;
          s2_q[i]    <= 1'b1;
          s3_q[i]    <= 1'b1;
          syncOut[i] <= 1'b1;
        end else begin
          s1_q[i] <= asyncIn[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            syncOut[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

// ---- rcld_cause.sv ----
`timescale 1ns/1ps
`include "rcld_defs.svh"
module rcld_cause (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  // events
  input  wire logic            clearAll,
  input  wire logic            wdogEvent,
  input  wire logic            lowvEvent,
  input  wire logic            readClear,
  // state
  output rcld_pkg::rcld_byte_t causeValue
);
  import rcld_pkg::*;
  logic wdFlag_q;
  logic lvFlag_q;
  logic wdFlag_d;
  logic lvFlag_d;
  // a new cause in the read cycle wins over the read clear
  assign wdFlag_d = wdogEvent | (wdFlag_q & ~readClear & ~clearAll);
  assign lvFlag_d = lowvEvent | (lvFlag_q & ~readClear & ~clearAll);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wdFlag_q <= 1'b0;
      lvFlag_q <= 1'b0;
    end else begin
      wdFlag_q <= wdFlag_d;
      lvFlag_q <= lvFlag_d;
    end
  end
  always_comb begin
    causeValue = `RCLD_RESET_VAL;
    causeValue[`RCLD_BIT_WDFLAG] = wdFlag_q;
    causeValue[`RCLD_BIT_LVFLAG] = lvFlag_q;
  end
  a_wd_sets: assert property (@(posedge ref_clk) disable iff (reset)
    wdogEvent |=> wdFlag_q) else $error("watchdog flag not set");
  a_lv_sets: assert property (@(posedge ref_clk) disable iff (reset)
    lowvEvent |=> lvFlag_q) else $error("lowvolt flag not set");
  a_read_clr: assert property (@(posedge ref_clk) disable iff (reset)
    (readClear && !wdogEvent) |=> !wdFlag_q)
    else $error("read did not clear");
  a_pin_clr: assert property (@(posedge ref_clk) disable iff (reset)
    (clearAll && !lowvEvent && !wdogEvent) |=> causeValue == 8'h00)
    else $error("clear did not clear");
endmodule

// ---- rcld_top.sv ----
`timescale 1ns/1ps
`include "rcld_defs.svh"
module rcld_top (
  // clock and power-clear reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // reset sources and comparators, asynchronous levels
  input  wire logic               extResetPin,
  input  wire logic               watchdogReset,
  input  wire logic               powerClearOk,
  input  wire logic               supplyAboveLevel,
  // internal bus, byte wide
  input  wire rcld_pkg::rcld_addr_t busAddr,
  input  wire rcld_pkg::rcld_byte_t busWdata,
  input  wire logic               busWrite,
  input  wire logic               busRead,
  input  wire logic               busBitWrite,
  input  wire logic [2:0]         busBitIndex,
  output rcld_pkg::rcld_byte_t    busRdata,
  // comparator control and events
  output logic                    comparatorOn,
  output rcld_pkg::rcld_level_t   levelCode,
  output logic                    lowvoltInterrupt,
  output logic                    internalReset
);
  import rcld_pkg::*;
  logic [3:0] syncRaw;
  logic [3:0] syncVal;
  logic       pinLow;
  logic       wdogLvl;
  logic       powerOk;
  logic       supplyOk;
  logic       enable_q;
  logic       mode_q;
  logic       wdogSeen_q;
  rcld_level_t level_q;
  rcld_byte_t  rdata_d;
  rcld_byte_t  causeValue;
  logic        selCtrl;
  logic        selLevel;
  logic        selCause;
  logic        wrCtrl;
  logic        wrLevel;
  logic        lowFlag;
  logic        lowvReset;
  logic        hardClear;
  logic        wdogEvent;
  logic        lowvEvent;
  logic        readClear;
  logic        ctrlEnable_d;
  logic        ctrlMode_d;

  // watchdog enters inverted so every stage presets to its idle level;
  // a preset of one on the raw request would fake a watchdog reset
  assign syncRaw = {supplyAboveLevel, powerClearOk, ~watchdogReset,
                    extResetPin};
  // pin input is active low reset, idles high
  rcld_sync3 #(.WIDTH(4)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn (syncRaw),
    .syncOut (syncVal)
  );
  assign pinLow   = ~syncVal[0];
  assign wdogLvl  = ~syncVal[1];
  assign powerOk  = syncVal[2];
  assign supplyOk = syncVal[3];

  assign selCtrl  = busAddr == `RCLD_ADDR_LVCTRL;
  assign selLevel = busAddr == `RCLD_ADDR_LVLSEL;
  assign selCause = busAddr == `RCLD_ADDR_CAUSE;
  assign wrCtrl   = selCtrl & (busWrite | busBitWrite);
  assign wrLevel  = selLevel & busWrite;
  // byte reads only clear; a bit read would lose the other flag
  assign readClear = selCause & busRead;

  // flag is forced low while comparator is off
  assign lowFlag = enable_q & ~supplyOk;
  assign lowvReset = enable_q & mode_q & ~supplyOk;
  // pin and power-clear wipe everything; watchdog wipes control and level, not the cause flags
  assign hardClear = pinLow | ~powerOk;
  assign wdogEvent = wdogLvl & ~wdogSeen_q;
  assign lowvEvent = lowvReset;

  // bit writes to the flag position fall through untouched
  always_comb begin
    ctrlEnable_d = enable_q;
    ctrlMode_d   = mode_q;
    if (busWrite) begin
      ctrlEnable_d = busWdata[`RCLD_BIT_ENABLE];
      ctrlMode_d   = busWdata[`RCLD_BIT_MODE];
    end else if (busBitIndex == 3'(`RCLD_BIT_ENABLE)) begin
      ctrlEnable_d = busWdata[0];
    end else if (busBitIndex == 3'(`RCLD_BIT_MODE)) begin
      ctrlMode_d = busWdata[0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable_q   <= 1'b0;
      mode_q     <= 1'b0;
      level_q    <= 4'h0;
      wdogSeen_q <= 1'b0;
    end else if (hardClear || wdogEvent) begin
      enable_q   <= 1'b0;
      mode_q     <= 1'b0;
      level_q    <= 4'h0;
      wdogSeen_q <= wdogLvl;
    end else begin
      wdogSeen_q <= wdogLvl;
      if (wrCtrl) begin
        enable_q <= ctrlEnable_d;
        mode_q   <= ctrlMode_d;
      end
      // prohibited codes are dropped, the old level stays
      if (wrLevel && busWdata[3:0] <= `RCLD_LEVEL_MAX) begin
        level_q <= busWdata[3:0];
      end
    end
  end

  rcld_cause u_cause (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clearAll   (hardClear),
    .wdogEvent  (wdogEvent),
    .lowvEvent  (lowvEvent),
    .readClear  (readClear),
    .causeValue (causeValue)
  );

  always_comb begin
    rdata_d = 8'h00;
    if (selCtrl) begin
      rdata_d[`RCLD_BIT_ENABLE] = enable_q;
      rdata_d[`RCLD_BIT_MODE]   = mode_q;
      rdata_d[`RCLD_BIT_FLAG]   = lowFlag;
    end else if (selLevel) begin
      rdata_d = {4'h0, level_q};
    end else if (selCause) begin
      rdata_d = causeValue;
    end
  end

  // low-voltage reset leaves control and level alone
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busRdata         <= 8'h00;
      comparatorOn     <= 1'b0;
      levelCode        <= 4'h0;
      lowvoltInterrupt <= 1'b0;
      internalReset    <= 1'b1;
    end else begin
      busRdata         <= rdata_d;
      comparatorOn     <= enable_q;
      levelCode        <= level_q;
      lowvoltInterrupt <= lowFlag & ~mode_q;
      internalReset    <= hardClear | wdogLvl | lowvReset;
    end
  end

  a_irq_follow: assert property (@(posedge ref_clk) disable iff (reset)
    (enable_q && !mode_q) |=> lowvoltInterrupt == $past(lowFlag))
    else $error("interrupt not following flag");
  a_reset_mode: assert property (@(posedge ref_clk) disable iff (reset)
    lowvReset |=> internalReset)
    else $error("lowvolt reset missing");
  a_flag_off: assert property (@(posedge ref_clk) disable iff (reset)
    (selCtrl && !enable_q) |=> !busRdata[`RCLD_BIT_FLAG])
    else $error("flag set while off");
  a_lv_keeps: assert property (@(posedge ref_clk) disable iff (reset)
    (lowvReset && !hardClear && !wdogEvent && !wrCtrl) |=>
    enable_q && mode_q) else $error("control lost");
  a_level_legal: assert property (@(posedge ref_clk) disable iff (reset)
    level_q <= 4'h9) else $error("illegal level code");
  a_poc_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !powerOk |=> internalReset) else $error("power reset missing");
  c_lv_reset: cover property (@(posedge ref_clk) lowvReset);
  c_irq: cover property (@(posedge ref_clk) lowvoltInterrupt);
  c_wdog: cover property (@(posedge ref_clk) wdogEvent);
  c_read: cover property (@(posedge ref_clk) readClear && causeValue != 0);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "rcld_defs.svh"
module tb_top;
  import rcld_pkg::*;
  logic        ref_clk, reset, extResetPin, watchdogReset;
  logic        powerClearOk, supplyAboveLevel, busWrite, busRead;
  logic        busBitWrite, comparatorOn, lowvoltInterrupt, internalReset;
  logic        rdPend;
  logic [2:0]  busBitIndex;
  rcld_addr_t  busAddr;
  rcld_byte_t  busWdata, busRdata, code;
  rcld_level_t levelCode;
  rcld_byte_t  expQ[$];
  int          err_total, check_count, cycles, i;

  rcld_top rcld_top_inst (.ref_clk(ref_clk), .reset(reset),
    .extResetPin(extResetPin), .watchdogReset(watchdogReset),
    .powerClearOk(powerClearOk), .supplyAboveLevel(supplyAboveLevel),
    .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
    .busRead(busRead), .busBitWrite(busBitWrite),
    .busBitIndex(busBitIndex), .busRdata(busRdata),
    .comparatorOn(comparatorOn), .levelCode(levelCode),
    .lowvoltInterrupt(lowvoltInterrupt), .internalReset(internalReset));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input rcld_byte_t e, input rcld_byte_t g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // comparator needs its settle time before the flag counts
  task automatic settle();
    idle(`RCLD_SETTLE_CYC);
  endtask

  // bounded wait; events hold off bus writes
  task automatic waitRel();
    int k;
    k = 0;
    while (internalReset !== 1'b0 && k < 40) begin
      idle(1);
      k++;
    end
    if (k == 40) cmp("releaseWait", 8'h00, 8'h01);
    idle(3);
  endtask

  task automatic wr(input rcld_addr_t a, input rcld_byte_t d);
    busAddr  = a;
    busWdata = d;
    busWrite = 1'b1;
    idle(1);
    busWrite = 1'b0;
    idle(1);
  endtask

  task automatic bw(input logic [2:0] b, input logic v);
    busAddr     = `RCLD_ADDR_LVCTRL;
    busBitIndex = b;
    busWdata    = {7'h00, v};
    busBitWrite = 1'b1;
    idle(1);
    busBitWrite = 1'b0;
    idle(1);
  endtask

  task automatic rd(input rcld_addr_t a, input rcld_byte_t e);
    busAddr = a;
    busRead = 1'b1;
    expQ.push_back(e);
    idle(1);
    busRead = 1'b0;
    idle(1);
  endtask

  task automatic lvPulse();
    supplyAboveLevel = 1'b0;
    idle(8);
    cmp("internalReset", 8'h01, {7'h00, internalReset});
    supplyAboveLevel = 1'b1;
    waitRel();
  endtask

  task automatic wdPulse();
    watchdogReset = 1'b1;
    idle(8);
    watchdogReset = 1'b0;
    waitRel();
  endtask

  // read data lands one cycle after the request
  always @(posedge ref_clk or posedge reset) begin
    if (reset) rdPend <= 1'b0;
    else rdPend <= busRead;
  end

  always @(negedge ref_clk) begin
    if (rdPend) begin
      if (expQ.size() == 0) cmp("readQueue", 8'h00, 8'hff);
      else cmp("busRdata", expQ.pop_front(), busRdata);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    reset = 1'b1; extResetPin = 1'b1; watchdogReset = 1'b0;
    powerClearOk = 1'b1; supplyAboveLevel = 1'b1; busAddr = 16'h0000;
    busWdata = 8'h00; busWrite = 1'b0; busRead = 1'b0;
    busBitWrite = 1'b0; busBitIndex = 3'h0;
    code = 8'($urandom(32'h2e3c));
    idle(3);
    reset = 1'b0;
    waitRel();
    idle(3);
    rd(`RCLD_ADDR_CAUSE, 8'h00);
    rd(`RCLD_ADDR_LVCTRL, 8'h00);
    rd(16'h0040, 8'h00);
    for (i = 0; i < 6; i++) begin
      code = 8'($urandom_range(9, 0));
      wr(`RCLD_ADDR_LVLSEL, code);
      rd(`RCLD_ADDR_LVLSEL, code);
      cmp("levelCode", code, {4'h0, levelCode});
    end
    wr(`RCLD_ADDR_LVLSEL, 8'h05);
    wr(`RCLD_ADDR_LVLSEL, 8'h0c);
    rd(`RCLD_ADDR_LVLSEL, 8'h05);
    // interrupt mode, supply low; bit 0 written but must not stick
    supplyAboveLevel = 1'b0;
    wr(`RCLD_ADDR_LVCTRL, 8'h81);
    settle();
    rd(`RCLD_ADDR_LVCTRL, 8'h81);
    cmp("comparatorOn", 8'h01, {7'h00, comparatorOn});
    cmp("lowvoltInterrupt", 8'h01, {7'h00, lowvoltInterrupt});
    bw(3'h0, 1'b0);
    rd(`RCLD_ADDR_LVCTRL, 8'h81);
    wr(`RCLD_ADDR_LVCTRL, 8'h00);
    idle(3);
    rd(`RCLD_ADDR_LVCTRL, 8'h00);
    cmp("lowvoltInterrupt", 8'h00, {7'h00, lowvoltInterrupt});
    supplyAboveLevel = 1'b1;
    bw(3'h7, 1'b1);
    settle();
    bw(3'h1, 1'b1);
    idle(8);
    rd(`RCLD_ADDR_LVCTRL, 8'h82);
    lvPulse();
    cmp("lowvoltInterrupt", 8'h00, {7'h00, lowvoltInterrupt});
    rd(`RCLD_ADDR_CAUSE, 8'h01);
    rd(`RCLD_ADDR_CAUSE, 8'h00);
    rd(`RCLD_ADDR_LVCTRL, 8'h82);
    rd(`RCLD_ADDR_LVLSEL, 8'h05);
    lvPulse();
    wdPulse();
    rd(`RCLD_ADDR_CAUSE, 8'h11);
    rd(`RCLD_ADDR_LVCTRL, 8'h00);
    rd(`RCLD_ADDR_LVLSEL, 8'h00);
    wdPulse();
    wr(`RCLD_ADDR_LVCTRL, 8'h82);
    settle();
    lvPulse();
    rd(`RCLD_ADDR_CAUSE, 8'h11);
    // pin reset must wipe the watchdog flag set just before it
    wdPulse();
    extResetPin = 1'b0;
    idle(8);
    extResetPin = 1'b1;
    waitRel();
    rd(`RCLD_ADDR_CAUSE, 8'h00);
    wdPulse();
    wr(`RCLD_ADDR_LVLSEL, 8'h03);
    powerClearOk = 1'b0;
    idle(8);
    cmp("internalReset", 8'h01, {7'h00, internalReset});
    powerClearOk = 1'b1;
    waitRel();
    rd(`RCLD_ADDR_CAUSE, 8'h00);
    rd(`RCLD_ADDR_LVLSEL, 8'h00);
    idle(4);
    conclude();
  end
endmodule
